// ### include/upm_mode_config_consts.svh
// constants for the two user machine mode registers
// assumes word-wide register port, big-endian field numbering mapped to [31:0]
`ifndef UPM_MODE_CONFIG_CONSTS_SVH
`define UPM_MODE_CONFIG_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_MODE_A        8'h00
`define OFS_MODE_B        8'h04

// ==========================================================
// field positions
`define FLD_PERIOD_LSB    24
`define FLD_EN_BIT        23
`define FLD_AMB_LSB       20
`define FLD_DSA_LSB       17
`define FLD_G0CL_LSB      13
`define FLD_L4OFF_BIT     12
`define FLD_RLF_LSB       8
`define FLD_WLF_LSB       4
`define FLD_TLF_LSB       0

// ==========================================================
// reset values and counts
`define MODE_A_RST        32'h0000_1000
`define MODE_B_RST        32'h0000_1000
`define LOOP_ZERO_PASSES  5'h10
`define LINE0_BASE_BIT    5'h13
`define MUX_BASE_SHIFT    5'h08

`endif

// ### include/upm_mode_config_pkg.sv
// types shared by the user machine configuration logic
// assumes upm_mode_config_consts.svh for numeric constants
`default_nettype none

package upm_mode_config_pkg;

	// ==========================================================
	// pattern kinds and loop states
	typedef enum logic [1:0] {
		PAT_READ  = 2'h0,
		PAT_WRITE = 2'h1,
		PAT_TIMER = 2'h2
	} pat_kind_t;

	typedef enum logic [1:0] {
		LOOP_IDLE = 2'b01,
		LOOP_RUN  = 2'b10
	} loop_state_t;

	// ==========================================================
	// register images
	typedef struct packed {
		logic       line4_off;
		logic [3:0] read_loop_count;
		logic [3:0] write_loop_count;
		logic [3:0] timer_loop_count;
	} mode_a_t;

	typedef struct packed {
		logic [7:0] refresh_period_b;
		logic       refresh_enable_b;
		logic [2:0] addr_mux_size_b;
		logic [1:0] same_bank_gap_period;
		logic [2:0] line0_addr_select_b;
		logic       line4_off;
		logic [3:0] read_loop_count;
		logic [3:0] write_loop_count;
		logic [3:0] timer_loop_count;
	} mode_b_t;

	// array word bits the configuration logic looks at
	typedef struct packed {
		logic line4_early_or_wait_enable_bit;
		logic line4_late_or_delay_bit;
		logic row_select;
		logic gap_timer_start_bit;
	} array_word_t;

	// ==========================================================
	// module state
	typedef struct packed {
		loop_state_t st;
		logic [4:0]  left;
	} loop_st_t;

	typedef struct packed {
		mode_a_t     a;
		mode_b_t     b;
		logic [31:0] rdata;
		logic [7:0]  tcnt;
		logic        req;
		logic [2:0]  gap_cnt;
		logic [2:0]  gap_bank;
		logic [1:0]  pin_out;
		logic        general_line_zero;
		logic [31:0] addr_out;
	} cfg_st_t;

endpackage

`default_nettype wire

// ### logic/upm_loop_counter.sv
// pass counter for one user machine's pattern loop
// assumes loop_end_i pulses once per loop pass while running
`default_nettype none
`include "upm_mode_config_consts.svh"

module upm_loop_counter (
	input  wire logic                           clk_i,
	input  wire logic                           resetn_i,
	input  wire logic                           start_i,
	input  wire upm_mode_config_pkg::pat_kind_t kind_i,
	input  wire logic [3:0]                     read_code_i,
	input  wire logic [3:0]                     write_code_i,
	input  wire logic [3:0]                     timer_code_i,
	input  wire logic                           loop_end_i,
	output logic                                repeat_o,
	output logic                                busy_o,
	output logic [4:0]                          passes_left_o
);

	upm_mode_config_pkg::loop_st_t s_q;
	upm_mode_config_pkg::loop_st_t s_d;
	logic [3:0]                    code;

	// ==========================================================
	// next state
	always_comb
	begin
		s_d = s_q;
		unique case (kind_i)
			upm_mode_config_pkg::PAT_WRITE: code = write_code_i;
			upm_mode_config_pkg::PAT_TIMER: code = timer_code_i;
			default:                        code = read_code_i;
		endcase
		unique case (s_q.st)
			upm_mode_config_pkg::LOOP_IDLE:
			begin
				if (start_i)
				begin
					// all-zero code means the widest count
					s_d.left = (code == 4'h0) ? `LOOP_ZERO_PASSES : {1'b0, code};
					s_d.st   = upm_mode_config_pkg::LOOP_RUN;
				end
			end
			upm_mode_config_pkg::LOOP_RUN:
			begin
				if (loop_end_i)
				begin
					if (s_q.left > 5'h01)
					begin
						s_d.left = s_q.left - 5'h01;
					end
					else
					begin
						s_d.left = 5'h00;
						s_d.st   = upm_mode_config_pkg::LOOP_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_q <= '{st: upm_mode_config_pkg::LOOP_IDLE, left: 5'h00};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign repeat_o      = (s_q.st == upm_mode_config_pkg::LOOP_RUN) && loop_end_i
		&& (s_q.left > 5'h01);
	assign busy_o        = (s_q.st == upm_mode_config_pkg::LOOP_RUN);
	assign passes_left_o = s_q.left;

	// ==========================================================
	// checks
	property p_zero_code_sixteen;
		@(posedge clk_i) disable iff (!resetn_i)
		start_i && !busy_o && (code == 4'h0) |=> (passes_left_o == 5'h10);
	endproperty
	a_zero_code_sixteen: assert property (p_zero_code_sixteen)
		else $error("zero loop code did not give sixteen passes");

endmodule

`default_nettype wire

// ### logic/upm_mode_config.sv
// mode registers of user machines a and b and the logic they steer
// assumes one clock, synchronous inputs, array bits supplied by the pattern sequencer
`default_nettype none
`include "upm_mode_config_consts.svh"

module upm_mode_config #(
	parameter int ADDR_W = 8
) (
	input  wire logic                                   clk_i,
	input  wire logic                                   resetn_i,
	input  wire logic [ADDR_W-1:0]                      reg_addr_i,
	input  wire logic [31:0]                            reg_wdata_i,
	input  wire logic                                   reg_wr_i,
	input  wire logic                                   reg_rd_i,
	output logic [31:0]                                 reg_rdata_o,
	input  wire logic [1:0]                             pattern_start_i,
	input  wire upm_mode_config_pkg::pat_kind_t [1:0]   pattern_kind_i,
	input  wire logic [1:0]                             loop_end_i,
	output logic [1:0]                                  loop_repeat_o,
	output logic [1:0]                                  loop_busy_o,
	input  wire upm_mode_config_pkg::array_word_t [1:0] array_word_i,
	input  wire logic [1:0]                             line4_pin_i,
	output logic [1:0]                                  line4_pin_o,
	output logic [1:0]                                  line4_pin_oe_o,
	output logic [1:0]                                  wait_o,
	output logic [1:0]                                  delay_o,
	input  wire logic                                   b_active_i,
	input  wire logic [31:0]                            mem_addr_i,
	input  wire logic [2:0]                             bank_i,
	input  wire logic                                   prescaled_tick_i,
	output logic                                        refresh_req_o,
	output logic                                        bank_busy_o,
	output logic                                        general_line_zero_o,
	output logic [31:0]                                 addr_o
);

	upm_mode_config_pkg::cfg_st_t s_q;
	upm_mode_config_pkg::cfg_st_t s_d;
	logic [1:0]                   line4_off;
	logic [3:0]                   rd_code [2];
	logic [3:0]                   wr_code [2];
	logic [3:0]                   tm_code [2];
	logic                         sel_a;
	logic                         sel_b;

	// ==========================================================
	// register images as bus words
	function automatic logic [31:0] pack_a(input upm_mode_config_pkg::mode_a_t m);
		logic [31:0] w;
		w                          = 32'h0000_0000;
		w[`FLD_L4OFF_BIT]          = m.line4_off;
		w[`FLD_RLF_LSB +: 4]       = m.read_loop_count;
		w[`FLD_WLF_LSB +: 4]       = m.write_loop_count;
		w[`FLD_TLF_LSB +: 4]       = m.timer_loop_count;
		return w;
	endfunction

	function automatic logic [31:0] pack_b(input upm_mode_config_pkg::mode_b_t m);
		logic [31:0] w;
		w                          = 32'h0000_0000;
		w[`FLD_PERIOD_LSB +: 8]    = m.refresh_period_b;
		w[`FLD_EN_BIT]             = m.refresh_enable_b;
		w[`FLD_AMB_LSB +: 3]       = m.addr_mux_size_b;
		w[`FLD_DSA_LSB +: 2]       = m.same_bank_gap_period;
		w[`FLD_G0CL_LSB +: 3]      = m.line0_addr_select_b;
		w[`FLD_L4OFF_BIT]          = m.line4_off;
		w[`FLD_RLF_LSB +: 4]       = m.read_loop_count;
		w[`FLD_WLF_LSB +: 4]       = m.write_loop_count;
		w[`FLD_TLF_LSB +: 4]       = m.timer_loop_count;
		return w;
	endfunction

	assign sel_a = (reg_addr_i == ADDR_W'(`OFS_MODE_A));
	assign sel_b = (reg_addr_i == ADDR_W'(`OFS_MODE_B));

	// ==========================================================
	// next state
	always_comb
	begin
		s_d = s_q;

		// bus: reserved positions are not stored, so they read back zero
		if (reg_wr_i && sel_a)
		begin
			s_d.a.line4_off        = reg_wdata_i[`FLD_L4OFF_BIT];
			s_d.a.read_loop_count  = reg_wdata_i[`FLD_RLF_LSB +: 4];
			s_d.a.write_loop_count = reg_wdata_i[`FLD_WLF_LSB +: 4];
			s_d.a.timer_loop_count = reg_wdata_i[`FLD_TLF_LSB +: 4];
		end
		if (reg_wr_i && sel_b)
		begin
			s_d.b.refresh_period_b     = reg_wdata_i[`FLD_PERIOD_LSB +: 8];
			s_d.b.refresh_enable_b     = reg_wdata_i[`FLD_EN_BIT];
			s_d.b.addr_mux_size_b      = reg_wdata_i[`FLD_AMB_LSB +: 3];
			s_d.b.same_bank_gap_period = reg_wdata_i[`FLD_DSA_LSB +: 2];
			s_d.b.line0_addr_select_b  = reg_wdata_i[`FLD_G0CL_LSB +: 3];
			s_d.b.line4_off            = reg_wdata_i[`FLD_L4OFF_BIT];
			s_d.b.read_loop_count      = reg_wdata_i[`FLD_RLF_LSB +: 4];
			s_d.b.write_loop_count     = reg_wdata_i[`FLD_WLF_LSB +: 4];
			s_d.b.timer_loop_count     = reg_wdata_i[`FLD_TLF_LSB +: 4];
		end
		// unmapped reads answer zero
		s_d.rdata = 32'h0000_0000;
		if (reg_rd_i && sel_a)
		begin
			s_d.rdata = pack_a(s_q.a);
		end
		if (reg_rd_i && sel_b)
		begin
			s_d.rdata = pack_b(s_q.b);
		end

		// refresh timer: one request every period ticks; period zero never fires
		s_d.req = 1'b0;
		if (!s_q.b.refresh_enable_b)
		begin
			s_d.tcnt = 8'h00;
		end
		else if (prescaled_tick_i)
		begin
			if ((s_q.b.refresh_period_b != 8'h00)
				&& (s_q.tcnt + 8'h01 >= s_q.b.refresh_period_b))
			begin
				s_d.tcnt = 8'h00;
				s_d.req  = 1'b1;
			end
			else
			begin
				s_d.tcnt = s_q.tcnt + 8'h01;
			end
		end

		// same-bank gap timer, b only; a has no timer here so cannot disturb it
		if (b_active_i && array_word_i[1].gap_timer_start_bit)
		begin
			s_d.gap_cnt  = {1'b0, s_q.b.same_bank_gap_period} + 3'h1;
			s_d.gap_bank = bank_i;
		end
		else if (s_q.gap_cnt != 3'h0)
		begin
			s_d.gap_cnt = s_q.gap_cnt - 3'h1;
		end

		// line4 output level follows the late timing bit of the array word
		for (int m = 0; m < 2; m++)
		begin
			s_d.pin_out[m] = !line4_off[m] && array_word_i[m].line4_late_or_delay_bit;
		end

		// line0 carries A12 for code 0 down to A5 for code 7
		s_d.general_line_zero = b_active_i
			&& mem_addr_i[`LINE0_BASE_BIT + {2'b00, s_q.b.line0_addr_select_b}];

		// row phase shifts the address down by eight plus the mux size code
		if (b_active_i && array_word_i[1].row_select)
		begin
			s_d.addr_out = mem_addr_i >> (`MUX_BASE_SHIFT + {2'b00, s_q.b.addr_mux_size_b});
		end
		else
		begin
			s_d.addr_out = mem_addr_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_q.a.line4_off        <= 1'(`MODE_A_RST >> `FLD_L4OFF_BIT);
			s_q.a.read_loop_count  <= 4'h0;
			s_q.a.write_loop_count <= 4'h0;
			s_q.a.timer_loop_count <= 4'h0;
			s_q.b                  <= '0;
			s_q.b.line4_off        <= 1'(`MODE_B_RST >> `FLD_L4OFF_BIT);
			s_q.rdata              <= 32'h0000_0000;
			s_q.tcnt               <= 8'h00;
			s_q.req                <= 1'b0;
			s_q.gap_cnt            <= 3'h0;
			s_q.gap_bank           <= 3'h0;
			s_q.pin_out            <= 2'h0;
			s_q.general_line_zero               <= 1'b0;
			s_q.addr_out           <= 32'h0000_0000;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// per-machine loop counters and line4 pins
	assign line4_off = {s_q.b.line4_off, s_q.a.line4_off};
	assign rd_code[0] = s_q.a.read_loop_count;
	assign wr_code[0] = s_q.a.write_loop_count;
	assign tm_code[0] = s_q.a.timer_loop_count;
	assign rd_code[1] = s_q.b.read_loop_count;
	assign wr_code[1] = s_q.b.write_loop_count;
	assign tm_code[1] = s_q.b.timer_loop_count;

	generate
		for (genvar m = 0; m < 2; m++)
		begin : g_mach
			// one counter each keeps a and b loops independent
			upm_loop_counter i_upm_loop_counter (
				.clk_i         (clk_i),
				.resetn_i      (resetn_i),
				.start_i       (pattern_start_i[m]),
				.kind_i        (pattern_kind_i[m]),
				.read_code_i   (rd_code[m]),
				.write_code_i  (wr_code[m]),
				.timer_code_i  (tm_code[m]),
				.loop_end_i    (loop_end_i[m]),
				.repeat_o      (loop_repeat_o[m]),
				.busy_o        (loop_busy_o[m]),
				.passes_left_o ()
			);
			assign line4_pin_oe_o[m] = !line4_off[m];
			assign wait_o[m]  = line4_off[m]
				&& array_word_i[m].line4_early_or_wait_enable_bit && line4_pin_i[m];
			assign delay_o[m] = line4_off[m] && array_word_i[m].line4_late_or_delay_bit;
		end
	endgenerate

	assign line4_pin_o         = s_q.pin_out;
	assign reg_rdata_o         = s_q.rdata;
	assign refresh_req_o       = s_q.req;
	assign general_line_zero_o = s_q.general_line_zero;
	assign addr_o              = s_q.addr_out;
	// busy only against the bank that armed the timer; others still served
	assign bank_busy_o = (s_q.gap_cnt != 3'h0) && (bank_i == s_q.gap_bank);

	// ==========================================================
	// checks
	property p_a_line4_role;
		@(posedge clk_i) disable iff (!resetn_i)
		reg_wr_i && sel_a |=> (line4_pin_oe_o[0] == !$past(reg_wdata_i[`FLD_L4OFF_BIT]));
	endproperty
	a_a_line4_role: assert property (p_a_line4_role)
		else $error("machine a line4 role does not follow its bit");

	property p_b_line4_wait;
		@(posedge clk_i) disable iff (!resetn_i)
		line4_off[1] |-> !line4_pin_oe_o[1] && (wait_o[1] == (line4_pin_i[1]
			&& array_word_i[1].line4_early_or_wait_enable_bit));
	endproperty
	a_b_line4_wait: assert property (p_b_line4_wait)
		else $error("machine b line4 not acting as wait input");

	property p_refresh_off;
		@(posedge clk_i) disable iff (!resetn_i)
		!s_q.b.refresh_enable_b |=> !refresh_req_o;
	endproperty
	a_refresh_off: assert property (p_refresh_off)
		else $error("refresh request while timer disabled");

	property p_refresh_period;
		@(posedge clk_i) disable iff (!resetn_i)
		refresh_req_o |-> $past(prescaled_tick_i)
			&& ($past(s_q.tcnt) + 8'h01 == $past(s_q.b.refresh_period_b));
	endproperty
	a_refresh_period: assert property (p_refresh_period)
		else $error("refresh request not at programmed period");

	property p_gap_four;
		@(posedge clk_i) disable iff (!resetn_i)
		b_active_i && array_word_i[1].gap_timer_start_bit
			&& (s_q.b.same_bank_gap_period == 2'h3) |=> (s_q.gap_cnt == 3'h4);
	endproperty
	a_gap_four: assert property (p_gap_four)
		else $error("gap code 3 did not give four cycles");

	property p_gap_other_bank;
		@(posedge clk_i) disable iff (!resetn_i)
		(bank_i != s_q.gap_bank) |-> !bank_busy_o;
	endproperty
	a_gap_other_bank: assert property (p_gap_other_bank)
		else $error("other bank blocked by gap timer");

	property p_line0_select;
		@(posedge clk_i) disable iff (!resetn_i)
		b_active_i && (s_q.b.line0_addr_select_b == 3'h0) && !reg_wr_i
			|=> (general_line_zero_o == $past(mem_addr_i[19]));
	endproperty
	a_line0_select: assert property (p_line0_select)
		else $error("line0 code 0 did not output A12");

	property p_sep_a;
		@(posedge clk_i) disable iff (!resetn_i)
		reg_wr_i && sel_a |=> $stable(s_q.b);
	endproperty
	a_sep_a: assert property (p_sep_a)
		else $error("write to machine a changed machine b");

	property p_b_read_loop;
		@(posedge clk_i) disable iff (!resetn_i)
		pattern_start_i[1] && !loop_busy_o[1]
			&& (pattern_kind_i[1] == upm_mode_config_pkg::PAT_READ)
			&& (s_q.b.read_loop_count == 4'h1) ##2 loop_end_i[1] |-> !loop_repeat_o[1];
	endproperty
	a_b_read_loop: assert property (p_b_read_loop)
		else $error("single pass read loop repeated");

endmodule

`default_nettype wire

// ### bench/mem_side_model.sv
// far-side memory model for the two shared line4 / wait pins
// assumes the device's enable is high while it drives its pin
`default_nettype none

module mem_side_model (
	input  wire logic [1:0] oe_i,
	input  wire logic [1:0] dev_i,
	input  wire logic [1:0] wait_req_i,
	output logic [1:0]      pin_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// wire level
	// memory drives wait only while the device has let go of the pin
	always_comb
		for (int m = 0; m < 2; m++)
			pin_o[m] = oe_i[m] ? dev_i[m] : wait_req_i[m];
endmodule

`default_nettype wire

// ### bench/test_upm_mode_config.sv
// self-checking bench for the user machine mode registers
// assumes the design top and the memory side model are compiled first
`default_nettype none
`include "upm_mode_config_consts.svh"

module test_upm_mode_config;
	timeunit 1ns;
	timeprecision 1ns;

	logic                                   clk_i = 1'b0;
	logic                                   resetn_i = 1'b0;
	logic [7:0]                             reg_addr = 8'h00;
	logic [31:0]                            reg_wdata = 32'h0;
	logic                                   reg_wr = 1'b0;
	logic                                   reg_rd = 1'b0;
	logic [31:0]                            rdata;
	logic [1:0]                             start = 2'h0;
	upm_mode_config_pkg::pat_kind_t [1:0]   kind;
	logic [1:0]                             lend = 2'h0;
	logic [1:0]                             rep, busy, pin_in, pin_out, pin_oe, wt, dly;
	upm_mode_config_pkg::array_word_t [1:0] aw;
	logic [1:0]                             wait_req = 2'h0;
	logic                                   b_act = 1'b0;
	logic [31:0]                            maddr = 32'h0;
	logic [2:0]                             bank = 3'h0;
	logic                                   tick = 1'b0;
	logic                                   req, bbusy, general_line_zero;
	logic [31:0]                            aout;
	int                                     n_fail = 0;
	int                                     cmp_count = 0;

	upm_mode_config i_upm_mode_config (
		.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.pattern_start_i(start), .pattern_kind_i(kind), .loop_end_i(lend),
		.loop_repeat_o(rep), .loop_busy_o(busy), .array_word_i(aw),
		.line4_pin_i(pin_in), .line4_pin_o(pin_out), .line4_pin_oe_o(pin_oe),
		.wait_o(wt), .delay_o(dly), .b_active_i(b_act), .mem_addr_i(maddr),
		.bank_i(bank), .prescaled_tick_i(tick), .refresh_req_o(req),
		.bank_busy_o(bbusy), .general_line_zero_o(general_line_zero), .addr_o(aout)
	);

	mem_side_model i_mem_side_model (
		.oe_i(pin_oe), .dev_i(pin_out), .wait_req_i(wait_req), .pin_o(pin_in)
	);

	always #25 clk_i = ~clk_i;

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		@(negedge clk_i);
		chk(rdata, exp);
	endtask

	// loop ends spaced out so each repeat flag is seen alone
	task automatic run_loop(input int m, input int k, input int n);
		@(posedge clk_i);
		start[m] <= 1'b1;
		kind[m] <= upm_mode_config_pkg::pat_kind_t'(k);
		@(posedge clk_i);
		start[m] <= 1'b0;
		for (int i = 1; i <= n; i++)
		begin
			@(negedge clk_i);
			chk({busy[m], busy[1-m]}, 2'b10);
			@(posedge clk_i);
			lend[m] <= 1'b1;
			@(negedge clk_i);
			chk(rep[m], i < n);
			@(posedge clk_i);
			lend[m] <= 1'b0;
		end
		@(negedge clk_i);
		chk(busy[m], 1'b0);
	endtask

	task automatic summarize();
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial
	begin
		kind = {upm_mode_config_pkg::PAT_READ, upm_mode_config_pkg::PAT_READ};
		aw = '0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(negedge clk_i);
		chk(pin_oe, 2'b00);
		rd_chk(`OFS_MODE_A, 32'h0000_1000);
		rd_chk(`OFS_MODE_B, 32'h0000_1000);
		wr(`OFS_MODE_B, 32'hFFFF_FFFF);
		rd_chk(`OFS_MODE_B, 32'hFFF6_FFFF);
		wr(`OFS_MODE_A, 32'hFFFF_FFFF);
		rd_chk(`OFS_MODE_A, 32'h0000_1FFF);
		rd_chk(`OFS_MODE_B, 32'hFFF6_FFFF);
		rd_chk(8'h08, 32'h0);
		// loop counts: one, sixteen from a zero code, fifteen
		for (int m = 0; m < 2; m++)
		begin
			wr(m ? `OFS_MODE_B : `OFS_MODE_A, 32'h0000_010F);
			run_loop(m, 0, 1);
			run_loop(m, 1, 16);
			run_loop(m, 2, 15);
		end
		// shared pin roles: driven line first, then wait input
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk_i);
			aw[m].line4_late_or_delay_bit <= 1'b1;
			aw[m].line4_early_or_wait_enable_bit <= 1'b1;
			wait_req[m] <= 1'b1;
			repeat (2) @(negedge clk_i);
			chk({pin_oe[m], pin_out[m], wt[m], dly[m]}, 4'b1100);
			wr(m ? `OFS_MODE_B : `OFS_MODE_A, 32'h0000_1000);
			repeat (2) @(negedge clk_i);
			chk({pin_oe[m], pin_out[m], wt[m], dly[m]}, 4'b0011);
			@(posedge clk_i);
			wait_req[m] <= 1'b0;
			aw[m] <= '0;
			@(negedge clk_i);
			chk(wt[m], 1'b0);
		end
		// refresh period of three ticks, then disabled
		for (int e = 1; e >= 0; e--)
		begin
			wr(`OFS_MODE_B, 32'h0300_1000 | (e << 23));
			for (int i = 1; i <= 6; i++)
			begin
				@(posedge clk_i);
				tick <= 1'b1;
				@(posedge clk_i);
				tick <= 1'b0;
				@(negedge clk_i);
				chk(req, e == 1 && i % 3 == 0);
				@(negedge clk_i);
				chk(req, 1'b0);
			end
		end
		// same-bank gap for every period code
		for (int g = 0; g < 4; g++)
		begin
			wr(`OFS_MODE_B, 32'h0000_1000 | (g << 17));
			@(posedge clk_i);
			b_act <= 1'b1;
			aw[1].gap_timer_start_bit <= 1'b1;
			bank <= 3'h5;
			@(posedge clk_i);
			b_act <= 1'b0;
			aw[1].gap_timer_start_bit <= 1'b0;
			for (int j = 0; j <= g + 1; j++)
			begin
				@(negedge clk_i);
				chk(bbusy, j <= g);
			end
			@(posedge clk_i);
			b_act <= 1'b1;
			aw[1].gap_timer_start_bit <= 1'b1;
			@(posedge clk_i);
			b_act <= 1'b0;
			aw[1].gap_timer_start_bit <= 1'b0;
			bank <= 3'h2;
			@(negedge clk_i);
			chk(bbusy, 1'b0);
			repeat (5) @(posedge clk_i); // next same-bank pattern after gap runs out
		end
		// line0 select and multiplex size, every code
		for (int s = 0; s < 8; s++)
		begin
			wr(`OFS_MODE_B, 32'h0000_1000 | (s << 20) | (s << 13));
			@(posedge clk_i);
			b_act <= 1'b1;
			aw[1].row_select <= 1'b1;
			maddr <= 32'hF000_0000 | (32'h1 << (19 + s));
			@(posedge clk_i);
			@(negedge clk_i);
			chk(general_line_zero, 1'b1);
			chk(aout, (32'hF000_0000 | (32'h1 << (19 + s))) >> (8 + s));
			@(posedge clk_i);
			b_act <= 1'b0;
			// line0 is registered, so the drop shows one edge later
			repeat (2) @(negedge clk_i);
			chk(general_line_zero, 1'b0);
		end
		summarize();
	end

	// ==========================================================
	// watchdog, far beyond the few hundred cycles the tests take
	initial
	begin
		#1000000;
		n_fail++;
		summarize();
	end
endmodule

`default_nettype wire
